//--- inc/sdr_defs.svh
`ifndef SDR_DEFS_SVH
`define SDR_DEFS_SVH

`define SDR_CLK_NS 100
`define SDR_CYC_UP(ns) (((ns) + `SDR_CLK_NS - 1) / `SDR_CLK_NS)
`define SDR_GAP(n) (((n) > 2) ? ((n) - 1) : 1)

`define SDR_ACT_TO_COL_NS 20
`define SDR_ROW_CYCLE_NS 66
`define SDR_BANK_TO_BANK_NS 15
`define SDR_ROW_ACTIVE_MIN_NS 44
`define SDR_PRECHARGE_NS 20
`define SDR_SELF_EXIT_NS 75
`define SDR_REFRESH_CYCLE_NS 66
`define SDR_REFRESH_INTERVAL_NS 15625
`define SDR_REFRESH_PERIOD_MS 64
`define SDR_REFRESH_COUNT 4096
`define SDR_INIT_WAIT_NS 100000

`define SDR_RCD_CYC `SDR_CYC_UP(`SDR_ACT_TO_COL_NS)
`define SDR_RC_CYC `SDR_CYC_UP(`SDR_ROW_CYCLE_NS)
`define SDR_RRD_CYC `SDR_CYC_UP(`SDR_BANK_TO_BANK_NS)
`define SDR_RAS_CYC `SDR_CYC_UP(`SDR_ROW_ACTIVE_MIN_NS)
`define SDR_RP_CYC `SDR_CYC_UP(`SDR_PRECHARGE_NS)
`define SDR_RFC_CYC `SDR_CYC_UP(`SDR_REFRESH_CYCLE_NS)
`define SDR_XSR_CYC ((`SDR_CYC_UP(`SDR_SELF_EXIT_NS) < 2) ? 2 : `SDR_CYC_UP(`SDR_SELF_EXIT_NS))
`define SDR_REFI_CYC (`SDR_REFRESH_INTERVAL_NS / `SDR_CLK_NS)
// Refresh raised early so a wait, a precharge and its gap still fit
`define SDR_REF_SLACK_CYC 6
`define SDR_REF_DUE_CYC (`SDR_REFI_CYC - `SDR_REF_SLACK_CYC)
`define SDR_INIT_CYC `SDR_CYC_UP(`SDR_INIT_WAIT_NS)
`define SDR_MRD_CYC 2
`define SDR_INIT_REFS 2
`define SDR_SELF_OSC_CYC 156

`define SDR_CL 2
`define SDR_MODE_WORD 12'h020
`define SDR_MODE_CL_LSB 4
`define SDR_MODE_BL_LSB 0
`define SDR_BL_FULL 3'h7
`define SDR_AP_BIT 10

`endif

//--- inc/sdr_pkg.sv
package sdr_pkg;
  typedef logic [31:0] sdr_word_t;
  typedef logic [22:0] sdr_uaddr_t;
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sdr_cmd_t;
  typedef enum logic [2:0] {
    C_INIT = 3'h0,
    C_INIT_REF = 3'h1,
    C_IDLE = 3'h2,
    C_SELF = 3'h3,
    C_SELF_EXIT = 3'h4
  } sdr_cstate_t;
endpackage : sdr_pkg

//--- inc/sdr_if.sv
interface sdr_if;
  import sdr_pkg::*;
  logic csN;
  sdr_cmd_t cmd;
  logic cke;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [3:0] dqm;
  sdr_word_t ctrlDq;
  logic ctrlDqOe;
  sdr_word_t devDq;
  logic [3:0] devDqOe;
  sdr_word_t dq;

  // Resolved data wire level per byte lane
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      dq[8*g +: 8] = devDqOe[g] ? devDq[8*g +: 8] : (ctrlDqOe ? ctrlDq[8*g +: 8] : 8'h00);
    end
  end

  modport ctrl (output csN, cmd, cke, ba, addr, dqm, ctrlDq, ctrlDqOe, input dq);
  modport dev (input csN, cmd, cke, ba, addr, dqm, dq, output devDq, devDqOe);
endinterface : sdr_if

//--- logic/sdr_dev_end.sv
`include "sdr_defs.svh"

module sdr_dev_end (
  input wire logic sys_clk,
  input wire logic sys_rst,
  sdr_if.dev mem,
  output logic inSelfRefresh,
  output logic [11:0] refreshRow
);
  import sdr_pkg::*;

  sdr_word_t store [0:2047];
  sdr_word_t pipeData [0:2];
  sdr_word_t merged;
  logic [2:0] casLat;
  logic [2:0] burstCode;
  logic selfRef;
  logic [7:0] oscCnt;
  logic rdOn;
  logic wrOn;
  logic fullPage;
  logic [1:0] bBank;
  logic [8:0] bCol;
  logic [3:0] bLeft;
  logic [3:0] len;
  logic [2:0] pipeValid;
  logic [3:0] mask1;
  logic [3:0] mask2;
  logic [1:0] tap;
  logic [10:0] idx;
  logic live;
  logic isRead;
  logic isWrite;
  logic isStop;
  logic newBurst;
  logic doRead;
  logic doWrite;
  logic burstGoesOn;

  assign live = mem.cke && !mem.csN && !selfRef;
  assign isRead = live && mem.cmd == CMD_READ;
  assign isWrite = live && mem.cmd == CMD_WRITE;
  assign isStop = live && mem.cmd == CMD_BST;
  assign newBurst = isRead || isWrite;
  assign doRead = isRead || (rdOn && !newBurst && !isStop);
  assign doWrite = isWrite || (wrOn && !newBurst && !isStop);
  assign idx = newBurst ? {mem.ba, mem.addr[8:0]} : {bBank, bCol};
  assign burstGoesOn = burstCode == `SDR_BL_FULL || len != 4'h1;
  assign inSelfRefresh = selfRef;

  always_comb begin
    case (burstCode)
      3'h1: len = 4'h2;
      3'h2: len = 4'h4;
      3'h3: len = 4'h8;
      default: len = 4'h1;
    endcase
  end

  // Burst engine
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdOn <= 1'b0;
      wrOn <= 1'b0;
      fullPage <= 1'b0;
      bBank <= 2'h0;
      bCol <= 9'h000;
      bLeft <= 4'h0;
    end else if (newBurst) begin
      bBank <= mem.ba;
      bCol <= mem.addr[8:0] + 9'h001;
      bLeft <= len - 4'h1;
      fullPage <= burstCode == `SDR_BL_FULL;
      rdOn <= isRead && burstGoesOn;
      wrOn <= isWrite && burstGoesOn;
    end else if (isStop) begin
      rdOn <= 1'b0;
      wrOn <= 1'b0;
    end else if (rdOn || wrOn) begin
      bCol <= bCol + 9'h001;
      if (!fullPage) begin
        bLeft <= bLeft - 4'h1;
        if (bLeft == 4'h1) begin
          rdOn <= 1'b0;
          wrOn <= 1'b0;
        end
      end
    end
  end

  // Write data merge, mask acts with no delay
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign merged[8*g +: 8] = mem.dqm[g] ? store[idx][8*g +: 8] : mem.dq[8*g +: 8];
    assign mem.devDqOe[g] = pipeValid[tap] && !mask2[g];
  end

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      store[idx] <= merged;
    end
  end

  // Read pipeline of CAS latency depth
  always_ff @(posedge sys_clk) begin
    pipeData[0] <= store[idx];
    pipeData[1] <= pipeData[0];
    pipeData[2] <= pipeData[1];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pipeValid <= 3'h0;
      mask1 <= 4'hF;
      mask2 <= 4'hF;
    end else begin
      mask1 <= mem.dqm;
      mask2 <= mask1;
      if (isWrite) begin
        pipeValid <= 3'h0;
      end else begin
        pipeValid <= {pipeValid[1:0], doRead};
      end
    end
  end

  assign tap = (casLat == 3'h1) ? 2'h0 : ((casLat == 3'h3) ? 2'h2 : 2'h1);
  assign mem.devDq = pipeData[tap];

  // Mode, refresh and self refresh
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      casLat <= 3'(`SDR_CL);
      burstCode <= 3'h0;
      selfRef <= 1'b0;
      oscCnt <= 8'h00;
      refreshRow <= 12'h000;
    end else begin
      if (live && mem.cmd == CMD_LMR) begin
        casLat <= mem.addr[`SDR_MODE_CL_LSB +: 3];
        burstCode <= mem.addr[`SDR_MODE_BL_LSB +: 3];
      end
      if (!selfRef && !mem.csN && !mem.cke && mem.cmd == CMD_REF) begin
        selfRef <= 1'b1;
      end else if (selfRef && mem.cke) begin
        selfRef <= 1'b0;
      end
      oscCnt <= (selfRef && oscCnt != 8'(`SDR_SELF_OSC_CYC - 1)) ? oscCnt + 8'h01 : 8'h00;
      if ((live && mem.cmd == CMD_REF) || (selfRef && oscCnt == 8'(`SDR_SELF_OSC_CYC - 1))) begin
        refreshRow <= refreshRow + 12'h001;
      end
    end
  end
endmodule : sdr_dev_end

//--- logic/sdr_ctrl_end.sv
`include "sdr_defs.svh"

// Behaviour
// - Burst stop cuts latest read or write
// - One refresh per command, internal row counter
// - 4,096 refreshes every 64ms
// - Refresh spaced every 15.625us or bursted
// - Self refresh is refresh with clock-enable low
// - In self refresh only clock-enable matters
// - Device refreshes itself on internal timebase
// - Stay in self refresh at least row-active minimum
// - Clock stable before clock-enable rises
// - Only no-ops for exit time, two clocks minimum
// - Resume auto refresh within 15.625us after exit
// - Activate row before reads or writes
// - Round minimum times up to whole clocks
// - Same bank: precharge first, row-cycle spacing
// - Different banks: bank-to-bank activate spacing
// - Read data after CAS latency, then each clock
// - Burst end floats pins; full page wraps
// - Read chains gaplessly, issued latency minus one
// - Read accepted on every clock
// - Write after read, one idle bus cycle; two here
// - Masks high two clocks before write
// - Write floats outputs; masks low at write
// - Each mask bit governs one byte lane
module sdr_ctrl_end (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire sdr_pkg::sdr_uaddr_t reqAddr,
  input wire sdr_pkg::sdr_word_t reqWdata,
  output logic reqReady,
  output logic rspValid,
  output sdr_pkg::sdr_word_t rspData,
  input wire logic selfRefReq,
  output logic selfRefActive,
  sdr_if.ctrl mem
);
  import sdr_pkg::*;

  sdr_cstate_t state;
  logic [10:0] timer;
  logic [1:0] initRefs;
  logic csN;
  sdr_cmd_t cmd;
  logic cke;
  logic [1:0] ba;
  logic [11:0] addr;
  logic [3:0] dqm;
  sdr_word_t dqOut;
  logic dqOe;
  logic bankOpen [0:3];
  logic [11:0] openRow [0:3];
  logic [3:0] rcdCnt [0:3];
  logic [3:0] rasCnt [0:3];
  logic [3:0] rcCnt [0:3];
  logic [3:0] rrdCnt;
  logic [3:0] rwGap;
  logic [7:0] refCnt;
  logic refDue;
  logic refSeen;
  logic [2:0] rdPipe;
  logic [1:0] reqBank;
  logic [11:0] reqRow;
  logic [8:0] reqCol;
  logic rowHit;
  logic canAccess;
  logic canAct;
  logic canClose;
  logic anyOpen;
  logic allRasDone;
  logic idleFree;

  assign mem.csN = csN;
  assign mem.cmd = cmd;
  assign mem.cke = cke;
  assign mem.ba = ba;
  assign mem.addr = addr;
  assign mem.dqm = dqm;
  assign mem.ctrlDq = dqOut;
  assign mem.ctrlDqOe = dqOe;

  assign reqBank = reqAddr[22:21];
  assign reqRow = reqAddr[20:9];
  assign reqCol = reqAddr[8:0];
  assign rowHit = bankOpen[reqBank] && openRow[reqBank] == reqRow;
  assign canAccess = rowHit && rcdCnt[reqBank] == 4'h0 && (!reqWrite || rwGap == 4'h0);
  assign canAct = !bankOpen[reqBank] && rcCnt[reqBank] == 4'h0 && rrdCnt == 4'h0;
  assign canClose = bankOpen[reqBank] && !rowHit && rasCnt[reqBank] == 4'h0;
  assign idleFree = state == C_IDLE && timer == 11'h000 && !refDue && !selfRefReq;
  assign reqReady = idleFree && reqValid && canAccess;
  assign refSeen = !csN && cmd == CMD_REF;

  always_comb begin
    anyOpen = 1'b0;
    allRasDone = 1'b1;
    for (int b = 0; b < 4; b++) begin
      anyOpen = anyOpen || bankOpen[b];
      allRasDone = allRasDone && (!bankOpen[b] || rasCnt[b] == 4'h0);
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= C_INIT;
      timer <= 11'(`SDR_INIT_CYC - 1);
      initRefs <= 2'h0;
      csN <= 1'b1;
      cmd <= CMD_NOP;
      cke <= 1'b1;
      ba <= 2'h0;
      addr <= 12'h000;
      dqm <= 4'hF;
      dqOut <= 32'h0000_0000;
      dqOe <= 1'b0;
    end else begin
      csN <= 1'b0;
      cmd <= CMD_NOP;
      dqm <= 4'hF;
      dqOe <= 1'b0;
      if (timer != 11'h000) begin
        timer <= timer - 11'h001;
      end else begin
        case (state)
          C_INIT: begin
            cmd <= CMD_PRE;
            addr <= 12'h400;
            timer <= 11'(`SDR_GAP(`SDR_RP_CYC));
            initRefs <= 2'(`SDR_INIT_REFS);
            state <= C_INIT_REF;
          end
          C_INIT_REF: begin
            if (initRefs != 2'h0) begin
              cmd <= CMD_REF;
              initRefs <= initRefs - 2'h1;
              timer <= 11'(`SDR_GAP(`SDR_RFC_CYC));
            end else begin
              cmd <= CMD_LMR;
              addr <= `SDR_MODE_WORD;
              timer <= 11'(`SDR_GAP(`SDR_MRD_CYC));
              state <= C_IDLE;
            end
          end
          C_IDLE: begin
            if (refDue || selfRefReq) begin
              if (anyOpen) begin
                if (allRasDone) begin
                  cmd <= CMD_PRE;
                  addr <= 12'h400;
                  timer <= 11'(`SDR_GAP(`SDR_RP_CYC));
                end
              end else if (refDue) begin
                cmd <= CMD_REF;
                timer <= 11'(`SDR_GAP(`SDR_RFC_CYC));
              end else begin
                cmd <= CMD_REF;
                cke <= 1'b0;
                timer <= 11'(`SDR_GAP(`SDR_RAS_CYC));
                state <= C_SELF;
              end
            end else if (reqValid) begin
              if (canAccess) begin
                cmd <= reqWrite ? CMD_WRITE : CMD_READ;
                ba <= reqBank;
                addr <= {3'h0, reqCol};
                dqm <= 4'h0;
                dqOut <= reqWdata;
                dqOe <= reqWrite;
                timer <= 11'h001;
              end else if (canAct) begin
                cmd <= CMD_ACT;
                ba <= reqBank;
                addr <= reqRow;
                timer <= 11'h001;
              end else if (canClose) begin
                cmd <= CMD_PRE;
                ba <= reqBank;
                addr <= 12'h000;
                timer <= 11'(`SDR_GAP(`SDR_RP_CYC));
              end
            end
          end
          C_SELF: begin
            if (!selfRefReq) begin
              cke <= 1'b1;
              timer <= 11'(`SDR_XSR_CYC - 1);
              state <= C_SELF_EXIT;
            end
          end
          C_SELF_EXIT: begin
            cmd <= CMD_REF;
            timer <= 11'(`SDR_GAP(`SDR_RFC_CYC));
            state <= C_IDLE;
          end
          default: begin
            state <= C_IDLE;
          end
        endcase
      end
    end
  end

  // Per-bank open row and timing record
  for (genvar b = 0; b < 4; b++) begin : g_bank
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        bankOpen[b] <= 1'b0;
        openRow[b] <= 12'h000;
        rcdCnt[b] <= 4'h0;
        rasCnt[b] <= 4'h0;
        rcCnt[b] <= 4'h0;
      end else begin
        rcdCnt[b] <= (rcdCnt[b] != 4'h0) ? rcdCnt[b] - 4'h1 : 4'h0;
        rasCnt[b] <= (rasCnt[b] != 4'h0) ? rasCnt[b] - 4'h1 : 4'h0;
        rcCnt[b] <= (rcCnt[b] != 4'h0) ? rcCnt[b] - 4'h1 : 4'h0;
        if (!csN && cmd == CMD_ACT && ba == 2'(b)) begin
          bankOpen[b] <= 1'b1;
          openRow[b] <= addr;
          rcdCnt[b] <= 4'(`SDR_RCD_CYC - 1);
          rasCnt[b] <= 4'(`SDR_RAS_CYC - 1);
          rcCnt[b] <= 4'(`SDR_RC_CYC - 1);
        end else if (!csN && cmd == CMD_PRE && (addr[`SDR_AP_BIT] || ba == 2'(b))) begin
          bankOpen[b] <= 1'b0;
        end
      end
    end
  end

  // Cross-bank spacing and read-to-write turnaround
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rrdCnt <= 4'h0;
      rwGap <= 4'h0;
    end else begin
      if (!csN && cmd == CMD_ACT) begin
        rrdCnt <= 4'(`SDR_RRD_CYC - 1);
      end else if (rrdCnt != 4'h0) begin
        rrdCnt <= rrdCnt - 4'h1;
      end
      if (!csN && cmd == CMD_READ) begin
        rwGap <= 4'(`SDR_CL + 1);
      end else if (rwGap != 4'h0) begin
        rwGap <= rwGap - 4'h1;
      end
    end
  end

  // Refresh interval timer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      refCnt <= 8'h00;
      refDue <= 1'b0;
    end else begin
      refDue <= (refCnt == 8'(`SDR_REF_DUE_CYC - 1) && !refDue) || (refDue && !refSeen);
      if (refSeen) begin
        refCnt <= 8'h00;
      end else if (refCnt != 8'(`SDR_REF_DUE_CYC - 1)) begin
        refCnt <= refCnt + 8'h01;
      end
    end
  end

  // Read data capture at CAS latency
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdPipe <= 3'h0;
      rspValid <= 1'b0;
      rspData <= 32'h0000_0000;
      selfRefActive <= 1'b0;
    end else begin
      rdPipe <= {rdPipe[1:0], !csN && cmd == CMD_READ};
      rspValid <= rdPipe[`SDR_CL - 1];
      if (rdPipe[`SDR_CL - 1]) begin
        rspData <= mem.dq;
      end
      selfRefActive <= state == C_SELF;
    end
  end
endmodule : sdr_ctrl_end

//--- sim/sdr_link_sva.sv
`include "sdr_defs.svh"

module sdr_link_sva (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic csN,
  input wire sdr_pkg::sdr_cmd_t cmd,
  input wire logic cke,
  input wire logic [1:0] ba,
  input wire logic [11:0] addr,
  input wire logic [3:0] dqm,
  input wire logic ctrlDqOe,
  input wire logic [3:0] devDqOe
);
  timeunit 1ns;
  timeprecision 1ns;
  import sdr_pkg::*;
  // No gap between refreshes may pass the distributed refresh spacing
  localparam int REFRESH_LIMIT = `SDR_REFI_CYC;
  logic issued;
  logic refArmed;
  logic [3:0] rowOpen;
  logic [8:0] sinceRef;
  assign issued = !csN && cke;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Open banks as seen on the pins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rowOpen <= 4'h0;
    end else if (issued && cmd == CMD_ACT) begin
      rowOpen[ba] <= 1'b1;
    end else if (issued && cmd == CMD_PRE) begin
      rowOpen <= addr[10] ? 4'h0 : (rowOpen & ~(4'h1 << ba));
    end
  end

  // Cycles since the last refresh command
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      refArmed <= 1'b0;
      sinceRef <= 9'h000;
    end else if (!csN && cmd == CMD_REF) begin
      refArmed <= 1'b1;
      sinceRef <= 9'h000;
    end else if (!cke) begin
      sinceRef <= 9'h000;
    end else if (sinceRef != 9'h1FF) begin
      sinceRef <= sinceRef + 9'h001;
    end
  end

  a_read_latency: assert property (issued && cmd == CMD_READ && dqm == 4'h0 |-> ##2 devDqOe == 4'hF)
    else $error("read data not driven two cycles after read");
  a_read_float: assert property (issued && cmd == CMD_READ ##1 !(issued && cmd == CMD_READ) |-> ##2 devDqOe == 4'h0)
    else $error("data pins still driven after burst end");
  a_lane_mask: assert property (devDqOe != 4'h0 |-> (devDqOe & $past(dqm, 2)) == 4'h0)
    else $error("masked lane driven");
  a_write_floats: assert property (issued && cmd == CMD_WRITE |=> devDqOe == 4'h0)
    else $error("device drives after write");
  a_write_masks: assert property (issued && cmd == CMD_WRITE |-> dqm == 4'h0 && ctrlDqOe)
    else $error("write with masks high or data not driven");
  a_read_to_write: assert property (issued && cmd == CMD_READ |=> (!(issued && cmd == CMD_WRITE))[*3])
    else $error("write too close after read");
  a_mask_before_write: assert property (issued && cmd == CMD_WRITE && $past(cmd, 2) != CMD_WRITE |-> $past(dqm, 2) == 4'hF)
    else $error("masks not high two cycles before write");
  a_active_first: assert property (issued && (cmd == CMD_READ || cmd == CMD_WRITE) |-> rowOpen[ba])
    else $error("column access to closed bank");
  a_activate_closed: assert property (issued && cmd == CMD_ACT |-> !rowOpen[ba])
    else $error("activate to open bank");
  a_self_entry: assert property ($fell(cke) |-> !csN && cmd == CMD_REF)
    else $error("clock enable dropped without refresh command");
  a_self_quiet: assert property (!cke |-> devDqOe == 4'h0)
    else $error("device drives in self refresh");
  a_exit_nops: assert property ($rose(cke) |-> (csN || cmd == CMD_NOP)[*2])
    else $error("command during self refresh exit");
  a_refresh_interval: assert property (refArmed |-> sinceRef < REFRESH_LIMIT)
    else $error("refresh interval exceeded");

  c_read: cover property (issued && cmd == CMD_READ ##2 devDqOe == 4'hF);
  c_write: cover property (issued && cmd == CMD_WRITE);
  c_self_entry: cover property ($fell(cke));
  c_self_exit: cover property ($rose(cke));
endmodule : sdr_link_sva

//--- sim/sdr_refresh_activate_read_test.sv
module sdram_refresh_activate_read_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sdr_pkg::*;
  localparam int TIMEOUT = 12000;
  typedef struct packed {logic wr; sdr_uaddr_t a; sdr_word_t d;} sdr_row_t;
  // Back-to-back traffic over banks, rows, lanes and read/write turnarounds
  sdr_row_t rows [11] = '{
    '{1'b1, 23'h000205, 32'h11223344}, '{1'b1, 23'h4007FF, 32'hA5C3F00F},
    '{1'b0, 23'h000205, 32'h11223344}, '{1'b0, 23'h4007FF, 32'hA5C3F00F},
    '{1'b1, 23'h0FFE10, 32'hFFFFFFFF}, '{1'b0, 23'h000205, 32'h11223344},
    '{1'b1, 23'h600000, 32'h00000001}, '{1'b0, 23'h0FFE10, 32'hFFFFFFFF},
    '{1'b0, 23'h600000, 32'h00000001}, '{1'b1, 23'h000205, 32'h80000000},
    '{1'b0, 23'h000205, 32'h80000000}};
  logic sys_clk;
  logic sys_rst;
  logic reqValid;
  logic reqWrite;
  sdr_uaddr_t reqAddr;
  sdr_word_t reqWdata;
  logic reqReady;
  logic rspValid;
  sdr_word_t rspData;
  logic selfRefReq;
  logic selfRefActive;
  logic inSelfRefresh;
  logic [11:0] refreshRow;
  logic [11:0] row0;
  logic countRefs;
  logic readySeen;
  sdr_word_t rd;
  int errCount;
  int nChecks;
  int cycles;
  int refSeen;

  sdr_if i_sdr_if ();
  sdr_ctrl_end i_sdr_ctrl_end (.sys_clk(sys_clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .selfRefReq(selfRefReq), .selfRefActive(selfRefActive), .mem(i_sdr_if.ctrl));
  sdr_dev_end i_sdr_dev_end (.sys_clk(sys_clk), .sys_rst(sys_rst), .mem(i_sdr_if.dev),
    .inSelfRefresh(inSelfRefresh), .refreshRow(refreshRow));
  sdr_link_sva i_sdr_link_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .csN(i_sdr_if.csN), .cmd(i_sdr_if.cmd),
    .cke(i_sdr_if.cke), .ba(i_sdr_if.ba), .addr(i_sdr_if.addr), .dqm(i_sdr_if.dqm),
    .ctrlDqOe(i_sdr_if.ctrlDqOe), .devDqOe(i_sdr_if.devDqOe));

  always #50 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input sdr_word_t seen, input sdr_word_t exp);
    nChecks = nChecks + 1;
    if (seen !== exp) begin
      errCount = errCount + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One request, held until taken; reads wait for the answer three edges on
  task automatic request(input logic wr, input sdr_uaddr_t a, input sdr_word_t d, output sdr_word_t data);
    int n;
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    n = 0;
    @(posedge sys_clk);
    while (reqReady !== 1'b1 && n < 2000) begin
      n++;
      @(posedge sys_clk);
    end
    check("request taken", sdr_word_t'(n < 2000), 32'h00000001);
    #10;
    reqValid = 1'b0;
    repeat (wr ? 1 : 3) @(posedge sys_clk);
    #10;
    data = rspData;
    if (!wr) begin
      check("read answer", sdr_word_t'(rspValid), 32'h00000001);
    end
  endtask : request

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (countRefs && !i_sdr_if.csN && i_sdr_if.cke && i_sdr_if.cmd == CMD_REF) begin
      refSeen <= refSeen + 1;
    end
    if (reqReady === 1'b1 && selfRefActive === 1'b1) begin
      readySeen <= 1'b1;
    end
    if (cycles == TIMEOUT) begin
      $display("timeout after %0d cycles", cycles);
      errCount = errCount + 1;
      report_and_stop();
    end
  end

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    {reqValid, reqWrite, selfRefReq, countRefs, readySeen} = 5'h00;
    reqAddr = 23'h000000;
    reqWdata = 32'h00000000;
    {errCount, nChecks, cycles, refSeen} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge sys_clk);
    #10;
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      request(rows[i].wr, rows[i].a, rows[i].d, rd);
      if (!rows[i].wr) begin
        check("table read", rd, rows[i].d);
      end
    end
    $display("test table done");
    // Each refresh command with clock-enable high advances the internal row counter by one
    row0 = refreshRow;
    countRefs = 1'b1;
    repeat (400) @(posedge sys_clk);
    #10;
    countRefs = 1'b0;
    check("refresh rows", sdr_word_t'(refreshRow - row0), sdr_word_t'(refSeen[11:0]));
    check("refresh rate", sdr_word_t'(refSeen >= 2), 32'h00000001);
    $display("test refresh done");
    selfRefReq = 1'b1;
    repeat (20) @(posedge sys_clk);
    #10;
    check("self active", sdr_word_t'(selfRefActive), 32'h00000001);
    check("clock enable", sdr_word_t'(i_sdr_if.cke), 32'h00000000);
    check("device self", sdr_word_t'(inSelfRefresh), 32'h00000001);
    row0 = refreshRow;
    reqValid = 1'b1;
    reqWrite = 1'b0;
    repeat (400) @(posedge sys_clk);
    #10;
    reqValid = 1'b0;
    check("refused in self", sdr_word_t'(readySeen), 32'h00000000);
    check("own refreshes", sdr_word_t'((refreshRow - row0) inside {12'h002, 12'h003}), 32'h00000001);
    selfRefReq = 1'b0;
    request(1'b0, 23'h000205, 32'h0, rd);
    check("retained data", rd, 32'h80000000);
    check("device out", sdr_word_t'(inSelfRefresh), 32'h00000000);
    $display("test self refresh done");
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #10;
    check("reset pins", sdr_word_t'({i_sdr_if.csN, i_sdr_if.cke, i_sdr_if.dqm}), 32'h0000003F);
    check("reset user", sdr_word_t'({reqReady, rspValid, inSelfRefresh, selfRefActive}), 32'h00000000);
    sys_rst = 1'b0;
    request(1'b1, 23'h4007FF, 32'h5A5A5A5A, rd);
    request(1'b0, 23'h4007FF, 32'h0, rd);
    check("after reset", rd, 32'h5A5A5A5A);
    $display("test reset done");
    report_and_stop();
  end
endmodule : sdram_refresh_activate_read_test
